// ### shared/host_port_pkg.sv
package host_port_pkg;

   // register select codes on host_reg_select
   localparam logic [1:0] SEL_CONTROL  = 2'h0;
   localparam logic [1:0] SEL_DATA_INC = 2'h1;
   localparam logic [1:0] SEL_ADDRESS  = 2'h2;
   localparam logic [1:0] SEL_DATA_FIX = 2'h3;

   // field positions inside the synchronised pin bundle
   localparam int PIN_DATA_LSB = 0;
   localparam int PIN_BE_LSB   = 32;
   localparam int PIN_RNW      = 36;
   localparam int PIN_SEL_LSB  = 37;
   localparam int PIN_HAS      = 39;
   localparam int PIN_STROBE   = 40;
   localparam int PIN_CS       = 41;
   localparam int PIN_W        = 42;

   // host byte address to word address
   localparam int WORD_SHIFT = 2;

   // reset values and the all-bytes enable mask
   localparam logic [31:0]      CONTROL_RESET = 32'h0000_0000;
   localparam logic [PIN_W-1:0] PINS_RESET    = {PIN_W{1'b1}};
   localparam logic [3:0]       BE_ALL        = 4'hF;

   // control register: bit that enables read prefetch
   localparam int CTRL_PREFETCH_EN = 0;

   // cycles an address write needs to settle in the core domain
   localparam logic [1:0] ADDR_SYNC_CYCLES = 2'h2;

   typedef enum logic [1:0] {
      HP_IDLE   = 2'b00,
      HP_START  = 2'b01,
      HP_ACTIVE = 2'b11,
      HP_END    = 2'b10
   } hp_state_t;

   typedef enum logic [1:0] {
      MEM_NONE     = 2'b00,
      MEM_WRITE    = 2'b01,
      MEM_DIRECT   = 2'b11,
      MEM_PREFETCH = 2'b10
   } mem_kind_t;

endpackage

// ### design/word_fifo.sv
module word_fifo import host_port_pkg::*; #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   input  wire logic                     flush,
   // fill side
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   // drain side
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data,
   output logic [$clog2(DEPTH+1)-1:0]    level
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
   } fifo_regs_t;

   fifo_regs_t r;
   fifo_regs_t next_r;
   logic       push;
   logic       pop;

   assign in_ready  = (r.count != CW'(DEPTH));
   assign out_valid = (r.count != '0);
   assign out_data  = r.mem[r.rd_ptr];
   assign level     = r.count;

   always_comb
   begin
      next_r = r;
      push   = in_valid && in_ready;
      pop    = out_valid && out_ready;
      if (push)
      begin
         next_r.mem[r.wr_ptr] = in_data;
         next_r.wr_ptr        = (r.wr_ptr == PW'(DEPTH-1)) ? '0 : r.wr_ptr + 1'b1;
      end
      if (pop)
         next_r.rd_ptr = (r.rd_ptr == PW'(DEPTH-1)) ? '0 : r.rd_ptr + 1'b1;
      next_r.count = r.count + CW'(push) - CW'(pop);
      // flush discards everything, including a push in the same cycle
      if (flush)
      begin
         next_r.wr_ptr = '0;
         next_r.rd_ptr = '0;
         next_r.count  = '0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         r <= '0;
      else if (clk_en)
         r <= next_r;
   end

endmodule // word_fifo

// ### design/host_port.sv
// Function
// - select code 00 control, 01 data incrementing, 10 address, 11 data fixed.
// - without address strobe, select and direction latch at internal strobe fall.
// - with address strobe, select and direction latch at its falling edge.
// - reads ignore all byte enables and return a full word.
// - write data and byte enables latch at internal strobe rising edge.
// - initial not-ready shows on ready only while chip select asserted.
// - not-ready after an access holds until chip select deasserts.
// - control and address reads never stall; incrementing reads with data start ready.
// - fixed reads stall first; incrementing reads stall on empty or flushing FIFO.
// - stalled incrementing read stalls again after completion if FIFO empties.
// - incrementing read that leaves the read FIFO empty stalls after completion.
// - control writes and settled address writes never stall; incrementing writes with space and no flush start ready.
// - address write stalls while the previous address write is still settling.
// - incrementing write stalls first when write FIFO full or flushing.
// - fixed write with FIFO busy stalls at start and after completion.
// - incrementing write into full FIFO, still full afterwards, stalls twice.
// - fixed write with FIFO idle starts ready, stalls after completion.
// - incrementing write that fills the write FIFO stalls after completion.
module host_port import host_port_pkg::*; #(
   parameter int ADDR_W   = 30,
   parameter int WF_DEPTH = 8,
   parameter int RF_DEPTH = 8
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // host pins
   input  wire logic              host_chip_select_n,
   input  wire logic              host_data_strobe_n,
   input  wire logic              host_address_strobe_n,
   input  wire logic [1:0]        host_reg_select,
   input  wire logic              host_read_not_write,
   input  wire logic [3:0]        host_byte_enables_n,
   input  wire logic [31:0]       host_data_in,
   output logic      [31:0]       host_data_out,
   output logic                   host_data_oe_n,
   output logic                   host_ready_n,
   // core memory port
   output logic                   mem_req,
   output logic                   mem_we,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic      [31:0]       mem_wdata,
   output logic      [3:0]        mem_be,
   input  wire logic              mem_ack,
   input  wire logic [31:0]       mem_rdata,
   // control register contents
   output logic      [31:0]       host_control_reg
);
   localparam int WF_W  = ADDR_W + 36;
   localparam int WFC_W = $clog2(WF_DEPTH+1);

   typedef struct packed {
      logic [PIN_W-1:0]  sync1;
      logic [PIN_W-1:0]  sync2;
      logic              strobe_prev;
      logic              has_prev;
      logic              has_held;
      logic [1:0]        has_sel;
      logic              has_rnw;
      hp_state_t         state;
      logic [1:0]        sel;
      logic              rnw;
      logic [31:0]       ctrl;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] pf_addr;
      logic [1:0]        addr_sync;
      logic              wflush;
      logic              rflush;
      logic [31:0]       rdata;
      mem_kind_t         mem_kind;
      logic              mem_drop;
      logic              mem_we;
      logic [ADDR_W-1:0] mem_addr;
      logic [31:0]       mem_wdata;
      logic [3:0]        mem_be;
      logic              direct_req;
      logic              direct_done;
      logic [31:0]       direct_data;
   } hp_regs_t;

   hp_regs_t          r;
   hp_regs_t          next_r;
   logic              cs_act;
   logic              strobe_act;
   logic              has_act;
   logic              strobe_fall;
   logic              strobe_rise;
   logic [1:0]        acc_sel;
   logic              acc_rnw;
   logic [31:0]       pin_data;
   logic [3:0]        pin_be;
   logic              wf_in_valid;
   logic              wf_in_ready;
   logic [WF_W-1:0]   wf_in_data;
   logic              wf_out_valid;
   logic              wf_out_ready;
   logic [WF_W-1:0]   wf_out_data;
   logic [WFC_W-1:0]  wf_level;
   logic              rf_flush;
   logic              rf_in_valid;
   logic              rf_in_ready;
   logic              rf_out_valid;
   logic              rf_out_ready;
   logic [31:0]       rf_out_data;
   logic              end_wait;

   // stall decision at the start of an access, also re-checked while stalled
   function automatic logic start_stall(input logic [1:0] sel,
                                        input logic       rnw,
                                        input logic       rf_empty,
                                        input logic       rflush,
                                        input logic       done,
                                        input logic       wf_full,
                                        input logic       wf_busy,
                                        input logic       wflush,
                                        input logic [1:0] async);
      logic stall;
      stall = 1'b0;
      if (rnw)
      begin
         unique case (sel)
            SEL_CONTROL,
            SEL_ADDRESS:  stall = 1'b0;
            SEL_DATA_INC: stall = rf_empty || rflush;
            SEL_DATA_FIX: stall = !done;
         endcase
      end
      else
      begin
         unique case (sel)
            SEL_CONTROL:  stall = 1'b0;
            SEL_ADDRESS:  stall = (async != 2'h0);
            SEL_DATA_INC: stall = wf_full || wflush;
            SEL_DATA_FIX: stall = wf_busy || wflush;
         endcase
      end
      return stall;
   endfunction

   // every host pin crosses two flops; the second stage alone is decoded
   assign cs_act      = !r.sync2[PIN_CS];
   assign strobe_act  = cs_act && !r.sync2[PIN_STROBE];
   assign has_act     = !r.sync2[PIN_HAS];
   assign strobe_fall = strobe_act && !r.strobe_prev;
   assign strobe_rise = !strobe_act && r.strobe_prev;
   assign pin_data    = r.sync2[PIN_DATA_LSB +: 32];
   assign pin_be      = ~r.sync2[PIN_BE_LSB +: 4];
   // a held address strobe capture takes precedence over the live pins
   assign acc_sel     = r.has_held ? r.has_sel : r.sync2[PIN_SEL_LSB +: 2];
   assign acc_rnw     = r.has_held ? r.has_rnw : r.sync2[PIN_RNW];

   // not-ready is only shown while the host holds chip select
   assign host_ready_n   = cs_act && (r.state == HP_START || r.state == HP_END);
   assign host_data_oe_n = !(r.state == HP_ACTIVE && r.rnw && strobe_act);
   assign host_data_out  = r.rdata;
   assign host_control_reg = r.ctrl;
   assign mem_req   = (r.mem_kind != MEM_NONE);
   assign mem_we    = r.mem_we;
   assign mem_addr  = r.mem_addr;
   assign mem_wdata = r.mem_wdata;
   assign mem_be    = r.mem_be;

   always_comb
   begin
      next_r       = r;
      wf_in_valid  = 1'b0;
      wf_in_data   = {r.addr, pin_be, pin_data};
      wf_out_ready = 1'b0;
      rf_flush     = 1'b0;
      rf_out_ready = 1'b0;
      rf_in_valid  = 1'b0;
      end_wait     = 1'b0;
      next_r.sync1 = {host_chip_select_n, host_data_strobe_n, host_address_strobe_n,
                      host_reg_select, host_read_not_write, host_byte_enables_n,
                      host_data_in};
      next_r.sync2       = r.sync1;
      next_r.strobe_prev = strobe_act;
      next_r.has_prev    = has_act;
      if (r.addr_sync != 2'h0)
         next_r.addr_sync = r.addr_sync - 2'h1;
      if (has_act && !r.has_prev)
      begin
         next_r.has_held = 1'b1;
         next_r.has_sel  = r.sync2[PIN_SEL_LSB +: 2];
         next_r.has_rnw  = r.sync2[PIN_RNW];
      end

      unique case (r.state)
         HP_IDLE:
            if (strobe_fall)
            begin
               next_r.sel      = acc_sel;
               next_r.rnw      = acc_rnw;
               next_r.has_held = 1'b0;
               if (acc_rnw && acc_sel == SEL_DATA_FIX)
               begin
                  next_r.direct_req  = 1'b1;
                  next_r.direct_done = 1'b0;
               end
               if (start_stall(acc_sel, acc_rnw, !rf_out_valid, r.rflush,
                               !(acc_rnw && acc_sel == SEL_DATA_FIX), !wf_in_ready,
                               wf_out_valid, r.wflush, r.addr_sync))
                  next_r.state = HP_START;
               else
                  next_r.state = HP_ACTIVE;
            end
         HP_START:
            if (!start_stall(r.sel, r.rnw, !rf_out_valid, r.rflush, r.direct_done,
                             !wf_in_ready, wf_out_valid, r.wflush, r.addr_sync))
               next_r.state = HP_ACTIVE;
         HP_ACTIVE:
            if (strobe_rise)
            begin
               if (r.rnw)
               begin
                  if (r.sel == SEL_DATA_INC)
                  begin
                     next_r.addr = r.addr + 1'b1;
                     end_wait    = !rf_out_valid;
                  end
               end
               else
               begin
                  unique case (r.sel)
                     SEL_CONTROL:
                        next_r.ctrl = pin_data;
                     SEL_ADDRESS:
                     begin
                        next_r.addr      = pin_data[31:WORD_SHIFT];
                        next_r.pf_addr   = pin_data[31:WORD_SHIFT];
                        next_r.addr_sync = ADDR_SYNC_CYCLES;
                        next_r.wflush    = wf_out_valid || r.mem_kind == MEM_WRITE;
                        rf_flush         = 1'b1;
                     end
                     SEL_DATA_INC:
                     begin
                        wf_in_valid = 1'b1;
                        next_r.addr = r.addr + 1'b1;
                        end_wait    = (wf_level == WFC_W'(WF_DEPTH-1));
                     end
                     SEL_DATA_FIX:
                     begin
                        wf_in_valid = 1'b1;
                        end_wait    = 1'b1;
                     end
                  endcase
               end
               next_r.state = end_wait ? HP_END : HP_IDLE;
            end
         HP_END:
            if (!cs_act)
               next_r.state = HP_IDLE;
      endcase

      // output word loads as the access turns ready; an incrementing read pops here
      if (next_r.state == HP_ACTIVE && r.state != HP_ACTIVE && next_r.rnw)
      begin
         unique case (next_r.sel)
            SEL_CONTROL:  next_r.rdata = r.ctrl;
            SEL_ADDRESS:  next_r.rdata = {r.addr, 2'b00};
            SEL_DATA_INC:
            begin
               next_r.rdata = rf_out_data;
               rf_out_ready = 1'b1;
            end
            SEL_DATA_FIX: next_r.rdata = r.direct_data;
         endcase
      end

      // core memory side: one transfer at a time, drain writes first
      if (r.mem_kind == MEM_NONE)
      begin
         if (wf_out_valid)
         begin
            wf_out_ready     = 1'b1;
            next_r.mem_kind  = MEM_WRITE;
            next_r.mem_we    = 1'b1;
            next_r.mem_addr  = wf_out_data[WF_W-1:36];
            next_r.mem_be    = wf_out_data[35:32];
            next_r.mem_wdata = wf_out_data[31:0];
         end
         else if (r.direct_req)
         begin
            next_r.direct_req = 1'b0;
            next_r.mem_kind   = MEM_DIRECT;
            next_r.mem_we     = 1'b0;
            next_r.mem_addr   = r.addr;
            next_r.mem_be     = BE_ALL;
         end
         else if (r.ctrl[CTRL_PREFETCH_EN] && rf_in_ready && !rf_flush)
         begin
            next_r.mem_kind = MEM_PREFETCH;
            next_r.mem_we   = 1'b0;
            next_r.mem_addr = r.pf_addr;
            next_r.mem_be   = BE_ALL;
            next_r.pf_addr  = r.pf_addr + 1'b1;
         end
      end
      else if (mem_ack)
      begin
         next_r.mem_kind = MEM_NONE;
         if (r.mem_kind == MEM_DIRECT)
         begin
            next_r.direct_data = mem_rdata;
            next_r.direct_done = 1'b1;
         end
         rf_in_valid = (r.mem_kind == MEM_PREFETCH) && !r.mem_drop && !rf_flush;
         next_r.mem_drop = 1'b0;
         next_r.rflush   = 1'b0;
      end
      // a prefetch in flight during a flush is dropped when it returns
      if (rf_flush && next_r.mem_kind == MEM_PREFETCH)
      begin
         next_r.mem_drop = 1'b1;
         next_r.rflush   = 1'b1;
      end
      if (r.wflush && !wf_out_valid && r.mem_kind != MEM_WRITE)
         next_r.wflush = 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         r          <= '0;
         r.sync1    <= PINS_RESET;
         r.sync2    <= PINS_RESET;
         r.state    <= HP_IDLE;
         r.mem_kind <= MEM_NONE;
         r.ctrl     <= CONTROL_RESET;
      end
      else if (clk_en)
         r <= next_r;
   end

   // write FIFO: full stalls the host through ready
   word_fifo #(.WIDTH(WF_W), .DEPTH(WF_DEPTH)) write_buf (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .flush     (1'b0),
      .in_valid  (wf_in_valid),
      .in_ready  (wf_in_ready),
      .in_data   (wf_in_data),
      .out_valid (wf_out_valid),
      .out_ready (wf_out_ready),
      .out_data  (wf_out_data),
      .level     (wf_level)
   );

   // read prefetch FIFO: discarded on every address write
   word_fifo #(.WIDTH(32), .DEPTH(RF_DEPTH)) read_buf (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .flush     (rf_flush),
      .in_valid  (rf_in_valid),
      .in_ready  (rf_in_ready),
      .in_data   (mem_rdata),
      .out_valid (rf_out_valid),
      .out_ready (rf_out_ready),
      .out_data  (rf_out_data),
      .level     ()
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst || !clk_en);

   a_ready_cs_gate:
   assert property (!cs_act |-> !host_ready_n)
      else $error("ready deasserted without chip select");

   a_end_hold:
   assert property (r.state == HP_END && cs_act
                    |=> r.state == HP_END && (host_ready_n || !cs_act))
      else $error("post-access stall released before chip select");

   a_ctrl_read_free:
   assert property (r.state == HP_IDLE && strobe_fall && acc_rnw && acc_sel == SEL_CONTROL
                    |=> r.state == HP_ACTIVE ##1 !host_ready_n)
      else $error("control read stalled");

   a_fix_read_stall:
   assert property (r.state == HP_IDLE && strobe_fall && acc_rnw && acc_sel == SEL_DATA_FIX
                    |=> r.state == HP_START)
      else $error("fixed read did not start stalled");

   a_addr_sync_stall:
   assert property (r.state == HP_IDLE && strobe_fall && !acc_rnw && acc_sel == SEL_ADDRESS
                    && r.addr_sync != 2'h0 |=> r.state == HP_START)
      else $error("address write not stalled while settling");

   a_full_write_stall:
   assert property (r.state == HP_IDLE && strobe_fall && !acc_rnw && acc_sel == SEL_DATA_INC
                    && !wf_in_ready |=> r.state == HP_START)
      else $error("incrementing write into full FIFO not stalled");

   a_write_capture:
   assert property (r.state == HP_ACTIVE && strobe_rise && !r.rnw && r.sel == SEL_DATA_INC
                    |-> wf_in_valid && wf_in_data[31:0] == pin_data)
      else $error("write data not captured at strobe rise");

   a_fix_write_after:
   assert property (r.state == HP_ACTIVE && strobe_rise && !r.rnw && r.sel == SEL_DATA_FIX
                    |=> r.state == HP_END)
      else $error("fixed write did not stall after completion");

   a_inc_addr_step:
   assert property (r.state == HP_ACTIVE && strobe_rise && r.sel == SEL_DATA_INC
                    |=> r.addr == $past(r.addr) + 1'b1)
      else $error("address did not advance by one word");

   a_read_full_word:
   assert property (mem_req && !mem_we |-> mem_be == BE_ALL)
      else $error("read issued with partial byte enables");

   a_direct_release:
   assert property (r.state == HP_START && r.rnw && r.sel == SEL_DATA_FIX && r.direct_done
                    |=> r.state == HP_ACTIVE && r.rdata == $past(r.direct_data))
      else $error("fixed read not released after fetch");

endmodule // host_port

// ### testbench/mem_model.sv
module mem_model #(
   parameter int ADDR_W = 30
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // high withholds every acknowledge
   input  wire logic              hold,
   // core memory port
   input  wire logic              mem_req,
   input  wire logic              mem_we,
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic [31:0]       mem_wdata,
   input  wire logic [3:0]        mem_be,
   output logic                   mem_ack,
   output logic      [31:0]       mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [256];
   int          cnt = 0;
   int          lat = 1;
   initial
   begin
      foreach (mem[i]) mem[i] = 32'h0;
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   // read data toggles outside a read acknowledge so stale data never looks valid
   always @(posedge ref_clk)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (sys_rst)
         cnt <= 0;
      else if (mem_req && !mem_ack && !hold)
      begin
         if (cnt < lat)
            cnt <= cnt + 1;
         else
         begin
            mem_ack <= 1'b1;
            cnt <= 0;
            lat <= $urandom_range(3, 0);
            if (!mem_we)
               mem_rdata <= mem[mem_addr[7:0]];
            for (int b = 0; b < 4; b++)
               if (mem_we && mem_be[b])
                  mem[mem_addr[7:0]][8*b+:8] <= mem_wdata[8*b+:8];
         end
      end
   end
endmodule // mem_model

// ### testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk = 0, sys_rst = 1, hold = 0, cs_n = 1, ds_n = 1, as_n = 1, rnw = 1;
   logic        ce = 1;
   logic [1:0]  sel = 2'h0;
   logic [3:0]  be_n = 4'hF, mbe;
   logic [31:0] din = 32'h0, dout, mwd, mrd, ctl, d;
   logic        oe_n, rdy_n, mreq, mwe, mack, oe_q = 1;
   logic [29:0] maddr;
   logic [31:0] shadow [256];
   logic [31:0] exp_q [$];
   int          err_total = 0, checks_done = 0;
   initial forever #12.5 ref_clk = ~ref_clk;
   host_port host_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce),
      .host_chip_select_n(cs_n), .host_data_strobe_n(ds_n), .host_address_strobe_n(as_n),
      .host_reg_select(sel), .host_read_not_write(rnw), .host_byte_enables_n(be_n),
      .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n),
      .host_ready_n(rdy_n), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr),
      .mem_wdata(mwd), .mem_be(mbe), .mem_ack(mack), .mem_rdata(mrd),
      .host_control_reg(ctl));
   mem_model mem_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .hold(hold),
      .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd), .mem_be(mbe),
      .mem_ack(mack), .mem_rdata(mrd));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, s);
         err_total++;
      end
   endtask
   task automatic summarize();
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ep/eq: stall expected before/after completion, 2 means either
   task automatic acc(input logic [1:0] s, input logic r, input logic [31:0] w,
      input logic [3:0] b, input logic a, input logic [31:0] er, input int ep, input int eq);
      int   n;
      logic pre;
      logic post;
      @(posedge ref_clk);
      sel <= s;
      rnw <= r;
      din <= w;
      be_n <= b;
      as_n <= !a;
      cs_n <= 1'b0;
      @(posedge ref_clk);
      ds_n <= 1'b0;
      if (r)
         exp_q.push_back(er);
      pre = 0;
      repeat (6) begin @(posedge ref_clk); pre |= rdy_n; end
      n = 0;
      while (rdy_n !== 1'b0 && n < 200) begin @(posedge ref_clk); n++; end
      if (n == 200)
         chk("ready_wait", 32'h0, 32'h1);
      // select lines disturbed once the strobe fall is captured
      sel <= ~s;
      as_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ds_n <= 1'b1;
      post = 0;
      repeat (6) begin @(posedge ref_clk); post |= rdy_n; end
      cs_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("ready_idle", 32'h0, {31'h0, rdy_n});
      if (ep < 2) chk("stall_start", ep, {31'h0, pre});
      if (eq < 2) chk("stall_end", eq, {31'h0, post});
   endtask
   // read data is taken as the device stops driving it, once the strobe rise is seen
   always @(posedge ref_clk)
   begin
      oe_q <= oe_n;
      if (oe_q === 1'b0 && oe_n === 1'b1)
         chk("read_data", exp_q.size() ? exp_q.pop_front() : 32'hX, dout);
   end
   initial
   begin
      void'($urandom(32'hAC407F2B));
      foreach (shadow[i]) shadow[i] = 32'h0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      acc(2'h0, 0, 32'h1, 4'h0, 0, 0, 0, 0);
      acc(2'h0, 1, 0, 4'h5, 1, 32'h1, 0, 0);
      acc(2'h2, 0, 32'h103, 4'h0, 0, 0, 0, 0);
      acc(2'h2, 1, 0, 4'hA, 0, 32'h100, 0, 0);
      hold <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         d = $urandom;
         shadow[64+i] = d;
         acc(2'h1, 0, d, 4'h0, i[0], 0, 0, i == 7 ? 2 : 0);
      end
      hold <= 1'b0;
      // acknowledges lost while frozen are repeated by the memory afterwards
      ce <= 1'b0;
      repeat (6) @(posedge ref_clk);
      ce <= 1'b1;
      repeat (80) @(posedge ref_clk);
      d = $urandom;
      shadow[64][15:0] = d[15:0];
      acc(2'h2, 0, 32'h100, 4'h0, 1, 0, 0, 0);
      acc(2'h3, 0, d, 4'hC, 1, 0, 0, 1);
      acc(2'h2, 0, 32'h104, 4'h0, 0, 0, 0, 0);
      acc(2'h3, 1, 0, 4'($urandom), 1, shadow[65], 1, 2);
      // memory held back so the first incrementing read finds the read FIFO empty
      hold <= 1'b1;
      acc(2'h2, 0, 32'h100, 4'h0, 0, 0, 0, 0);
      fork
         acc(2'h1, 1, 0, 4'h3, 0, shadow[64], 1, 2);
         begin
            repeat (30) @(posedge ref_clk);
            hold <= 1'b0;
         end
      join
      // prefetch now runs well ahead of the host, so no read stalls
      for (int i = 1; i < 8; i++)
         acc(2'h1, 1, 0, 4'h3, i[0], shadow[64+i], 0, 0);
      repeat (20) @(posedge ref_clk);
      chk("reads_left", 32'h0, exp_q.size());
      summarize();
   end
endmodule // tb_top
